// ### verilog/mms_consts.vh
// constants of the module management and status block
// assumes: included by bare name from the design files under verilog/
`ifndef MMS_CONSTS_VH
`define MMS_CONSTS_VH

// system clock rate
`define MMS_CLK_KHZ         200000
// timing figures in their own units
`define MMS_T_INIT_MS       2000
`define MMS_T_RESET_MIN_US  2
// derived cycle counts (least reset pulse rounds up; exact at 200 MHz)
`define MMS_INIT_CYCLES     (`MMS_T_INIT_MS * `MMS_CLK_KHZ)
`define MMS_RESET_MIN_CYC   ((`MMS_T_RESET_MIN_US * `MMS_CLK_KHZ + 999) / 1000)

// two-wire bus device address, 7 bits
`define MMS_BUS_ADDR        7'h50

// lower memory offsets
`define MMS_OFS_STATUS      8'h02
`define MMS_OFS_LOS_FLAG    8'h03
`define MMS_OFS_TXF_FLAG    8'h04
`define MMS_OFS_PWR_CTRL    8'h5D
`define MMS_OFS_BYPASS      8'h62
`define MMS_OFS_LOS_MASK    8'h64
`define MMS_OFS_TXF_MASK    8'h65
`define MMS_OFS_PAGE_SEL    8'h7F
// upper page 03 offsets
`define MMS_PAGE_CODES      8'h03
`define MMS_OFS_EQ_LO       8'hEA
`define MMS_OFS_EQ_HI       8'hEB
`define MMS_OFS_EMPH_LO     8'hEC
`define MMS_OFS_EMPH_HI     8'hED
`define MMS_OFS_AMPL_LO     8'hEE
`define MMS_OFS_AMPL_HI     8'hEF

// field positions
`define MMS_BIT_NOT_READY   0
`define MMS_BIT_INIT_FLAG   1
`define MMS_BIT_PWR_OVR     0

// reset values
`define MMS_RST_BYPASS      8'h00
`define MMS_RST_CODES       16'h0000
`define MMS_RST_MASK        4'h0
`define MMS_RST_PAGE        8'h00

`endif

// ### verilog/mms_sync.v
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes: one system clock, synchronous active-high reset
`timescale 1ns/100ps

module mms_sync #(
  parameter WIDTH   = 1,
  parameter RST_VAL = 1'b0
) (
  input  wire             clk_sys_in, // system clock
  input  wire             rst_in,     // synchronous reset, active high
  input  wire [WIDTH-1:0] async_in,   // level from another domain
  output reg  [WIDTH-1:0] sync_out    // level safe to use
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta     <= {WIDTH{RST_VAL}};
      sync_out <= {WIDTH{RST_VAL}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ### verilog/mms_top.v
// management-side control and status of a four-lane pluggable module
// assumes: host drives the two-wire bus and the discrete pins; all pins asynchronous
// What this block does
// - byte 98 holds per-channel clock-recovery bypass
// - amplitude codes, four ranges, upper codes reserved
// - equalization codes 0 to 10 dB, rest reserved
// - emphasis codes 0 to 7 dB, rest reserved
// - fully functional within 2000 ms after reset
// - reset pin low beyond 2 us resets
// - bus answers within 2000 ms of power-on
// - clear not-ready bit and raise interrupt when ready
// - low-power pin high enters low power quickly
// - interrupt line low within 200 ms of cause
// - flags clear on read, interrupt line releases
// - loss-of-signal sets flag and interrupt within 100 ms
// - transmit fault sets flag and interrupt within 200 ms
// - other flags set and interrupt within 200 ms
// - mask bits inhibit and restore their interrupt sources
// - module select gates bus answers within 100 us
// - power override bit forces low power, clears back
`timescale 1ns/100ps
`include "mms_consts.vh"

module mms_top #(
  parameter [31:0] INIT_CYCLES = `MMS_INIT_CYCLES
) (
  input  wire        clk_sys_in,              // system clock, 200 MHz
  input  wire        rst_in,                  // power-on reset, active high
  input  wire        scl_in,                  // two-wire bus clock pin
  input  wire        sda_in,                  // two-wire bus data pin level
  output reg         sda_out,                 // data pin drive value, always low
  output reg         sda_oe_out,              // high while pulling data pin low
  input  wire        module_reset_n_in,       // module reset pin, active low
  input  wire        low_power_select_in,     // low-power select pin
  input  wire        module_select_n_in,      // module select pin, active low
  input  wire [3:0]  rx_los_in,               // per-channel receive loss of signal
  input  wire [3:0]  tx_fault_in,             // per-channel transmit fault
  output reg         module_interrupt_n_out,  // interrupt line, active low
  output reg         low_power_out,           // module in lower power level
  output reg         fully_functional_out,    // initialisation complete
  output reg  [7:0]  cdr_bypass_out,          // clock-recovery bypass byte
  output reg  [15:0] tx_eq_out,               // equalization codes, 4 channels
  output reg  [15:0] rx_emph_out,             // emphasis codes, 4 channels
  output reg  [15:0] rx_ampl_out              // amplitude codes, 4 channels
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_ACK_A = 3'h2;
  localparam ST_OFS   = 3'h3;
  localparam ST_ACK_O = 3'h4;
  localparam ST_WR    = 3'h5;
  localparam ST_ACK_W = 3'h6;
  localparam ST_RD    = 3'h7;

  localparam [31:0] RESET_MIN = `MMS_RESET_MIN_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire       scl_s;
  wire       sda_s;
  wire       mrst_n_s;
  wire       lp_s;
  wire       sel_n_s;
  wire [3:0] los_s;
  wire [3:0] txf_s;

  mms_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_scl (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (scl_in),
    .sync_out   (scl_s)
  );

  mms_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_sda (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (sda_in),
    .sync_out   (sda_s)
  );

  mms_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_mrst (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (module_reset_n_in),
    .sync_out   (mrst_n_s)
  );

  mms_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_lp (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (low_power_select_in),
    .sync_out   (lp_s)
  );

  mms_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_sel (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (module_select_n_in),
    .sync_out   (sel_n_s)
  );

  mms_sync #(.WIDTH(4), .RST_VAL(1'b0)) u_sync_los (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (rx_los_in),
    .sync_out   (los_s)
  );

  mms_sync #(.WIDTH(4), .RST_VAL(1'b0)) u_sync_txf (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (tx_fault_in),
    .sync_out   (txf_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // module reset pin: only a low pulse longer than the least width counts

  reg [15:0] rst_low_cnt;
  reg        mrst;

  // glitches shorter than the least width are filtered out
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_low_cnt <= 16'h0000;
      mrst        <= 1'b0;
    end else if (mrst_n_s) begin
      rst_low_cnt <= 16'h0000;
      mrst        <= 1'b0;
    end else if ({16'h0000, rst_low_cnt} >= RESET_MIN) begin
      mrst        <= 1'b1;
    end else begin
      rst_low_cnt <= rst_low_cnt + 16'h0001;
    end
  end

  wire rst_all = rst_in | mrst;

  //////////////////////////////////////////////////////////////////////////////
  // initialisation timer

  reg [31:0] init_cnt;
  reg        ready;

  // ready falls back only on a reset, so the timer runs once per reset
  always @(posedge clk_sys_in) begin
    if (rst_all) begin
      init_cnt <= 32'h0000_0000;
      ready    <= 1'b0;
    end else if (!ready) begin
      if (init_cnt >= INIT_CYCLES - 32'h0000_0001) begin
        ready <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-wire bus edge and condition detection

  reg scl_q;
  reg sda_q;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  // answers only out of reset and while selected
  wire bus_en    = ~mrst & ~sel_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // register file state

  reg [7:0] page;
  reg       pwr_ovr;
  reg [3:0] los_flag;
  reg [3:0] txf_flag;
  reg       init_flag;
  reg [3:0] los_mask;
  reg [3:0] txf_mask;
  reg [3:0] los_q;
  reg [3:0] txf_q;
  reg       ready_q;

  // read data for the current pointer
  reg [7:0] rd_byte;
  reg [7:0] ptr;

  always @* begin
    rd_byte = 8'h00;
    case (ptr)
      `MMS_OFS_STATUS:   rd_byte = {6'h00, init_flag, ~ready};
      `MMS_OFS_LOS_FLAG: rd_byte = {4'h0, los_flag};
      `MMS_OFS_TXF_FLAG: rd_byte = {4'h0, txf_flag};
      `MMS_OFS_PWR_CTRL: rd_byte = {7'h00, pwr_ovr};
      `MMS_OFS_BYPASS:   rd_byte = cdr_bypass_out;
      `MMS_OFS_LOS_MASK: rd_byte = {4'h0, los_mask};
      `MMS_OFS_TXF_MASK: rd_byte = {4'h0, txf_mask};
      `MMS_OFS_PAGE_SEL: rd_byte = page;
      default: begin
        if (page == `MMS_PAGE_CODES) begin
          case (ptr)
            `MMS_OFS_EQ_LO:   rd_byte = tx_eq_out[7:0];
            `MMS_OFS_EQ_HI:   rd_byte = tx_eq_out[15:8];
            `MMS_OFS_EMPH_LO: rd_byte = rx_emph_out[7:0];
            `MMS_OFS_EMPH_HI: rd_byte = rx_emph_out[15:8];
            `MMS_OFS_AMPL_LO: rd_byte = rx_ampl_out[7:0];
            `MMS_OFS_AMPL_HI: rd_byte = rx_ampl_out[15:8];
            default:          rd_byte = 8'h00;
          endcase
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-wire bus slave

  reg [2:0] state;
  reg       in_mack;
  reg [2:0] bit_cnt;
  reg       got_byte;
  reg [7:0] shreg;
  reg       rw;
  reg       master_ack;
  reg       wr_stb;
  reg [7:0] wr_adr;
  reg [7:0] wr_dat;
  reg       clr_stb;
  reg [7:0] clr_adr;

  // data changes on the falling clock edge, or is released at once on start, stop or deselect; sampling on the rising one
  always @(posedge clk_sys_in) begin
    if (rst_all) begin
      state      <= ST_IDLE;
      in_mack    <= 1'b0;
      bit_cnt    <= 3'h0;
      got_byte   <= 1'b0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      ptr        <= 8'h00;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_stb     <= 1'b0;
      wr_adr     <= 8'h00;
      wr_dat     <= 8'h00;
      clr_stb    <= 1'b0;
      clr_adr    <= 8'h00;
    end else begin
      wr_stb  <= 1'b0;
      clr_stb <= 1'b0;
      if (bus_stop || (!bus_en && state != ST_IDLE)) begin
        // deselect or stop releases the line at once
        state      <= ST_IDLE;
        in_mack    <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (bus_start && bus_en) begin
        state      <= ST_ADDR;
        in_mack    <= 1'b0;
        bit_cnt    <= 3'h0;
        got_byte   <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (in_mack) begin
          master_ack <= ~sda_s;
        end else if (state == ST_ADDR || state == ST_OFS || state == ST_WR ||
                     state == ST_RD) begin
          if (state != ST_RD) begin
            shreg <= {shreg[6:0], sda_s};
          end
          bit_cnt  <= bit_cnt + 3'h1;
          got_byte <= (bit_cnt == 3'h7);
        end
      end else if (scl_fall) begin
        got_byte <= 1'b0;
        if (in_mack) begin
          in_mack <= 1'b0;
          if (master_ack) begin
            // next byte of a sequential read; flags clear on read
            shreg      <= rd_byte;
            sda_oe_out <= ~rd_byte[7];
            ptr        <= ptr + 8'h01;
            clr_stb    <= 1'b1;
            clr_adr    <= ptr;
            bit_cnt    <= 3'h0;
            state      <= ST_RD;
          end else begin
            sda_oe_out <= 1'b0;
            state      <= ST_IDLE;
          end
        end else begin
          case (state)
            ST_ADDR: begin
              if (got_byte) begin
                if (shreg[7:1] == `MMS_BUS_ADDR) begin
                  rw         <= shreg[0];
                  sda_oe_out <= 1'b1;
                  state      <= ST_ACK_A;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
            ST_ACK_A: begin
              bit_cnt <= 3'h0;
              if (rw) begin
                shreg      <= rd_byte;
                sda_oe_out <= ~rd_byte[7];
                ptr        <= ptr + 8'h01;
                clr_stb    <= 1'b1;
                clr_adr    <= ptr;
                state      <= ST_RD;
              end else begin
                sda_oe_out <= 1'b0;
                state      <= ST_OFS;
              end
            end
            ST_OFS: begin
              if (got_byte) begin
                ptr        <= shreg;
                sda_oe_out <= 1'b1;
                state      <= ST_ACK_O;
              end
            end
            ST_ACK_O, ST_ACK_W: begin
              sda_oe_out <= 1'b0;
              bit_cnt    <= 3'h0;
              state      <= ST_WR;
            end
            ST_WR: begin
              if (got_byte) begin
                wr_stb     <= 1'b1;
                wr_adr     <= ptr;
                wr_dat     <= shreg;
                ptr        <= ptr + 8'h01;
                sda_oe_out <= 1'b1;
                state      <= ST_ACK_W;
              end
            end
            ST_RD: begin
              if (got_byte) begin
                sda_oe_out <= 1'b0;
                in_mack    <= 1'b1;
              end else begin
                sda_oe_out <= ~shreg[6];
                shreg      <= {shreg[6:0], 1'b0};
              end
            end
            default: begin
              sda_oe_out <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // writable controls; codes stored whole, reserved values included

  always @(posedge clk_sys_in) begin
    if (rst_all) begin
      page           <= `MMS_RST_PAGE;
      pwr_ovr        <= 1'b0;
      los_mask       <= `MMS_RST_MASK;
      txf_mask       <= `MMS_RST_MASK;
      cdr_bypass_out <= `MMS_RST_BYPASS;
      tx_eq_out      <= `MMS_RST_CODES;
      rx_emph_out    <= `MMS_RST_CODES;
      rx_ampl_out    <= `MMS_RST_CODES;
    end else if (wr_stb) begin
      case (wr_adr)
        `MMS_OFS_PAGE_SEL: page           <= wr_dat;
        `MMS_OFS_PWR_CTRL: pwr_ovr        <= wr_dat[`MMS_BIT_PWR_OVR];
        `MMS_OFS_LOS_MASK: los_mask       <= wr_dat[3:0];
        `MMS_OFS_TXF_MASK: txf_mask       <= wr_dat[3:0];
        `MMS_OFS_BYPASS:   cdr_bypass_out <= wr_dat;
        default: begin
          if (page == `MMS_PAGE_CODES) begin
            case (wr_adr)
              `MMS_OFS_EQ_LO:   tx_eq_out[7:0]    <= wr_dat;
              `MMS_OFS_EQ_HI:   tx_eq_out[15:8]   <= wr_dat;
              `MMS_OFS_EMPH_LO: rx_emph_out[7:0]  <= wr_dat;
              `MMS_OFS_EMPH_HI: rx_emph_out[15:8] <= wr_dat;
              `MMS_OFS_AMPL_LO: rx_ampl_out[7:0]  <= wr_dat;
              `MMS_OFS_AMPL_HI: rx_ampl_out[15:8] <= wr_dat;
              default: begin
              end
            endcase
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latched flags: set on entering a condition, set wins over clear-on-read

  wire clr_status = clr_stb && (clr_adr == `MMS_OFS_STATUS);
  wire clr_los    = clr_stb && (clr_adr == `MMS_OFS_LOS_FLAG);
  wire clr_txf    = clr_stb && (clr_adr == `MMS_OFS_TXF_FLAG);

  always @(posedge clk_sys_in) begin
    if (rst_all) begin
      los_q     <= 4'h0;
      txf_q     <= 4'h0;
      ready_q   <= 1'b0;
      los_flag  <= 4'h0;
      txf_flag  <= 4'h0;
      init_flag <= 1'b0;
    end else begin
      los_q     <= los_s;
      txf_q     <= txf_s;
      ready_q   <= ready;
      los_flag  <= (los_flag & {4{~clr_los}}) | (los_s & ~los_q);
      txf_flag  <= (txf_flag & {4{~clr_txf}}) | (txf_s & ~txf_q);
      init_flag <= (init_flag & ~clr_status) | (ready & ~ready_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin outputs, each one flop after its cause

  always @(posedge clk_sys_in) begin
    if (rst_all) begin
      module_interrupt_n_out <= 1'b1;
      low_power_out          <= 1'b0;
      fully_functional_out   <= 1'b0;
    end else begin
      // masked sources never reach the line, cleared flags release it
      module_interrupt_n_out <= ~(|(los_flag & ~los_mask) |
                                  |(txf_flag & ~txf_mask) |
                                  init_flag);
      low_power_out          <= lp_s | pwr_ovr;
      fully_functional_out   <= ready;
    end
  end

endmodule

// ### tb/mms_top_checker.sv
// port checker for the management and status block, bound into mms_top
// assumes: one clock domain, synchronous active-high rst_in
`timescale 1ns/100ps
module mms_top_checker #(
  parameter [31:0] INIT_CYCLES = 32'h17D78400
) (
  input wire        clk_sys_in,             // system clock
  input wire        rst_in,                 // reset, active high
  input wire        scl_in,                 // bus clock pin
  input wire        sda_oe_out,             // device pulls data low
  input wire        module_reset_n_in,      // reset pin
  input wire        low_power_select_in,    // low-power pin
  input wire        module_select_n_in,     // select pin
  input wire        module_interrupt_n_out, // interrupt line
  input wire        low_power_out,          // low power state
  input wire        fully_functional_out,   // init done
  input wire [7:0]  cdr_bypass_out,         // bypass byte
  input wire [15:0] tx_eq_out,              // equalization codes
  input wire [15:0] rx_emph_out,            // emphasis codes
  input wire [15:0] rx_ampl_out             // amplitude codes
);
  reg  [31:0] up_cnt;
  reg  [15:0] low_cnt;
  wire [55:0] codes = {cdr_bypass_out, tx_eq_out, rx_emph_out, rx_ampl_out};
  // cycles since any reset let go; the pin may not be synced yet, hence the slack
  always @(posedge clk_sys_in) begin
    if (rst_in || !module_reset_n_in)
      up_cnt <= 32'h00000000;
    else if (up_cnt != 32'hFFFFFFFF)
      up_cnt <= up_cnt + 32'h00000001;
  end
  // length of the present low pulse on the reset pin
  always @(posedge clk_sys_in) begin
    if (rst_in || module_reset_n_in)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF)
      low_cnt <= low_cnt + 16'h0001;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  sequence s_int_low;
    ##[0:3] !module_interrupt_n_out;
  endsequence
  sequence s_lp_on;
    ##[1:5] low_power_out;
  endsequence
  a_reset_idle: assert property (
    $fell(rst_in) |-> module_interrupt_n_out && !fully_functional_out && codes == 56'h0
      && !low_power_out && !sda_oe_out) else $error("outputs not idle after reset");
  a_ready_time: assert property (
    $rose(fully_functional_out) |-> up_cnt >= INIT_CYCLES
      && up_cnt <= INIT_CYCLES + 32'h00000010) else $error("ready at wrong time");
  a_ready_int: assert property (
    $rose(fully_functional_out) |-> s_int_low) else $error("no interrupt when ready");
  a_lp_enter: assert property (
    $rose(low_power_select_in) && module_reset_n_in |-> s_lp_on)
    else $error("low power not entered");
  a_deselect_quiet: assert property (
    module_select_n_in [*5] |-> !sda_oe_out) else $error("drives data while deselected");
  a_short_ignored: assert property (
    $rose(module_reset_n_in) && low_cnt <= 16'h0186 && fully_functional_out
      |=> fully_functional_out [*4]) else $error("short pulse reset the module");
  a_long_resets: assert property (
    $rose(module_reset_n_in) && low_cnt >= 16'h01A4 |-> !fully_functional_out
      && codes == 56'h0) else $error("long pulse did not reset");
  a_oe_scl_low: assert property (
    $rose(sda_oe_out) |-> !scl_in) else $error("data driven while bus clock high");
  a_codes_by_bus: assert property (
    !$stable(codes) && module_reset_n_in |-> !scl_in)
    else $error("control codes changed outside a bus write");
endmodule

bind mms_top mms_top_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .module_reset_n_in(module_reset_n_in), .low_power_select_in(low_power_select_in),
  .module_select_n_in(module_select_n_in), .module_interrupt_n_out(module_interrupt_n_out),
  .low_power_out(low_power_out), .fully_functional_out(fully_functional_out),
  .cdr_bypass_out(cdr_bypass_out), .tx_eq_out(tx_eq_out), .rx_emph_out(rx_emph_out),
  .rx_ampl_out(rx_ampl_out));

// ### tb/mms_host_model.sv
// host side of the two-wire management bus, open-drain data with pull-up
// assumes: 200 MHz clock; bus clock 125 ns, 12 cycles low and 13 high
`timescale 1ns/100ps
module mms_host_model (
  input  wire clk_sys_in, // system clock
  input  wire sda_oe_in,  // device pulls data low
  output reg  scl_out,    // bus clock, stands high between frames
  output wire sda_out     // resolved data wire
);
  reg rel;
  // pull-up wins unless either party pulls low
  assign sda_out = rel & ~sda_oe_in;
  initial begin
    scl_out = 1'b1;
    rel = 1'b1;
  end
  ////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one bus clock: data set mid-low, sampled mid-high
  task clk_bit(input bo, output bi);
    rel <= bo;
    tick(6);
    scl_out <= 1'b1;
    tick(7);
    bi = sda_out;
    tick(6);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task start;
    rel <= 1'b1;
    tick(6);
    scl_out <= 1'b1;
    tick(13);
    rel <= 1'b0;
    tick(12);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task stop;
    rel <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(13);
    rel <= 1'b1;
    tick(13);
  endtask
  task xfer(input [7:0] d, input ab, output [7:0] q, output ackd);
    integer i;
    reg     b;
    for (i = 7; i >= 0; i = i - 1)
      clk_bit(d[i], q[i]);
    clk_bit(ab, b);
    ackd = ~b;
  endtask
  // write n bytes low first, or read n bytes after a repeated start
  task access(input [6:0] dev, input rnw, input [7:0] ofs, input integer n,
              input [15:0] wd, output [15:0] rdat, output ok);
    integer   k;
    reg [7:0] q;
    reg       a;
    rdat = 16'h0000;
    start;
    xfer({dev, 1'b0}, 1'b1, q, ok);
    xfer(ofs, 1'b1, q, a);
    ok = ok & a;
    if (rnw) begin
      start;
      xfer({dev, 1'b1}, 1'b1, q, a);
      ok = ok & a;
      for (k = 0; k < n; k = k + 1) begin
        xfer(8'hFF, k == n - 1, q, a);
        rdat[8*k +: 8] = q;
      end
    end else begin
      for (k = 0; k < n; k = k + 1) begin
        xfer(wd[8*k +: 8], 1'b1, q, a);
        ok = ok & a;
      end
    end
    stop;
  endtask
endmodule

// ### tb/tb_mms_top.sv
// self-checking bench for the management and status block
// assumes: host model owns the bus; pins change at clock rising edges
`timescale 1ns/100ps
module tb_mms_top;
  reg         clk, rst, mrst_n, lp, msel_n, ok;
  reg  [3:0]  los, txf;
  reg  [15:0] d;
  reg  [23:0] rows [0:4];
  wire        scl, sda, sdo, oe, int_n, lpo, ff;
  wire [7:0]  cdr;
  wire [15:0] eq, emph, ampl;
  integer     bad_count, n_tests, i, nb;
  mms_top #(.INIT_CYCLES(32'h000007D0)) i_dut (
    .clk_sys_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
    .sda_oe_out(oe), .module_reset_n_in(mrst_n), .low_power_select_in(lp),
    .module_select_n_in(msel_n), .rx_los_in(los), .tx_fault_in(txf),
    .module_interrupt_n_out(int_n), .low_power_out(lpo), .fully_functional_out(ff),
    .cdr_bypass_out(cdr), .tx_eq_out(eq), .rx_emph_out(emph), .rx_ampl_out(ampl));
  mms_host_model i_host (.clk_sys_in(clk), .sda_oe_in(oe), .scl_out(scl), .sda_out(sda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog well past the expected 30k cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count = bad_count + 1;
    summarize;
  end
  ////////////////////////////////////////
  task chk(input string nm, input [15:0] e, input [15:0] s);
    n_tests = n_tests + 1;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      bad_count = bad_count + 1;
    end
  endtask
  task endt(input string nm);
    $display("test %s done, %0d checks, %0d mismatches", nm, n_tests, bad_count);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input [7:0] o, input integer n, input [15:0] v);
    i_host.access(7'h50, 1'b0, o, n, v, d, ok);
  endtask
  task rd(input [7:0] o, input integer n);
    i_host.access(7'h50, 1'b1, o, n, 16'h0000, d, ok);
  endtask
  task wait_ff;
    integer k;
    for (k = 0; k < 3000 && ff !== 1'b1; k = k + 1)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk("ready", 16'h0001, {15'h0000, ff});
  endtask
  function [15:0] outv(input [7:0] o);
    case (o)
      8'h62:   outv = {8'h00, cdr};
      8'hEA:   outv = eq;
      8'hEC:   outv = emph;
      default: outv = ampl;
    endcase
  endfunction
  // mask, raise the cause, then read the flag byte that it set
  task flag_case(input [7:0] mo, input [3:0] p, input is_los, input masked);
    wr(mo, 1, {12'h000, (masked ? p : 4'h0)});
    if (is_los)
      los <= p;
    else
      txf <= p;
    repeat (20) @(posedge clk);
    chk("flag interrupt", {15'h0000, masked}, {15'h0000, int_n});
    rd(mo - 8'h61, 1);
    chk("flag byte", {12'h000, p}, d);
    chk("flag released", 16'h0001, {15'h0000, int_n});
    los <= 4'h0;
    txf <= 4'h0;
  endtask
  ////////////////////////////////////////
  initial begin
    bad_count = 0;
    n_tests = 0;
    {rst, mrst_n, lp, msel_n, los, txf} <= 12'hC00;
    rows[0] = 24'h6200A5;
    rows[1] = 24'hEABA98;
    rows[2] = 24'hEA0A01;
    rows[3] = 24'hECF870;
    rows[4] = 24'hEE4C30;
    repeat (16) @(posedge clk);
    chk("reset idle", 16'h0001, {13'h0000, sdo, ff, int_n});
    chk("reset codes", 16'h0000, eq | emph | ampl | {8'h00, cdr});
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h02, 1);
    chk("status early", 16'h0001, d);
    wait_ff;
    chk("ready interrupt", 16'h0000, {15'h0000, int_n});
    rd(8'h02, 1);
    chk("status ready", 16'h0002, d);
    chk("interrupt clear", 16'h0001, {15'h0000, int_n});
    rd(8'h02, 1);
    chk("status cleared", 16'h0000, d);
    endt("init");
    wr(8'h7F, 1, 16'h0003);
    for (i = 0; i < 5; i = i + 1) begin
      nb = (rows[i][23:16] == 8'h62) ? 1 : 2;
      wr(rows[i][23:16], nb, rows[i][15:0]);
      chk("control out", rows[i][15:0], outv(rows[i][23:16]));
      rd(rows[i][23:16], nb);
      chk("read back", rows[i][15:0], d);
    end
    endt("codes");
    wr(8'h7F, 1, 16'h0000);
    wr(8'hEE, 2, 16'h1111);
    chk("page gate", 16'h4C30, ampl);
    rd(8'h10, 1);
    chk("unmapped", 16'h0000, d);
    i_host.access(7'h21, 1'b0, 8'h62, 1, 16'h0000, d, ok);
    chk("foreign address", 16'h00A5, {7'h00, ok, cdr});
    lp <= 1'b1;
    repeat (5) @(posedge clk);
    chk("low power pin", 16'h0001, {15'h0000, lpo});
    lp <= 1'b0;
    repeat (5) @(posedge clk);
    chk("full power", 16'h0000, {15'h0000, lpo});
    wr(8'h5D, 1, 16'h0001);
    chk("override on", 16'h0001, {15'h0000, lpo});
    wr(8'h5D, 1, 16'h0000);
    chk("override off", 16'h0003, {14'h0000, ff, ~lpo});
    endt("power");
    flag_case(8'h64, 4'h4, 1'b1, 1'b0);
    flag_case(8'h65, 4'h1, 1'b0, 1'b1);
    flag_case(8'h65, 4'h2, 1'b0, 1'b0);
    endt("flags");
    msel_n <= 1'b1;
    repeat (5) @(posedge clk);
    wr(8'h62, 1, 16'h005A);
    chk("deselected", 16'h00A5, {7'h00, ok, cdr});
    msel_n <= 1'b0;
    repeat (5) @(posedge clk);
    wr(8'h62, 1, 16'h005A);
    chk("reselected", 16'h015A, {7'h00, ok, cdr});
    endt("select");
    mrst_n <= 1'b0;
    repeat (100) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("short pulse", 16'h015A, {7'h00, ff, cdr});
    mrst_n <= 1'b0;
    repeat (500) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("long pulse", 16'h0000, {7'h00, ff, cdr});
    wait_ff;
    chk("ready again", 16'h0000, {15'h0000, int_n});
    endt("pin reset");
    summarize;
  end
endmodule
